// file: rtl/fsp_pkg.sv
// package: constants and types of the flash status register bank
// Notes on behaviour
// - busy bit high during any internal cycle
// - no write enable latch, refuse writes
// - nonzero protect field blocks program/erase there
// - protect field frozen in hardware protected mode
// - chip erase only with no protection, lock
// - boot lock guards chosen sector or block
// - lock bit plus low pin freezes status, unless pin disabled or quad mode
// - otp mode remaps bits seven to three
// - top/bottom select, default top, otp written
// - granularity bit: one sector or block
// - pin disable bit kills protect, hold pins
// - quad mode overrides pin disable bit
// - function select: hold when 0, reset 1
// - disabled pin serves only as data
// - otp lock blocks otp sector, once only
// - busy bit equals second register bit zero
// - register three readable always, repeating
// - dummy field codes three, two, four, five
// - drive field codes 67,100,50,33 percent
// - register three bits 7,6,1,0 reserved
// - status register readable at any moment
// - latch cleared at power-up, cycle end
package fsp_pkg;
    localparam logic [7:0] CMD_SET_WEL  = 8'h06;
    localparam logic [7:0] CMD_CLR_WEL  = 8'h04;
    localparam logic [7:0] CMD_RD_STAT  = 8'h05;
    localparam logic [7:0] CMD_RD_STAT3 = 8'h95;
    localparam logic [7:0] CMD_WR_STAT  = 8'h01;
    localparam int         SR_WIP       = 0;
    localparam int         SR_WEL       = 1;
    localparam int         SR_BP_LO     = 2;
    localparam int         SR_EBL       = 6;
    localparam int         SR_SRP       = 7;
    localparam int         SR_TB        = 3;
    localparam int         SR_BL4K      = 4;
    localparam int         SR_PFS       = 5;
    localparam int         SR_CPD       = 6;
    localparam int         SR_OTPL      = 7;
    localparam int         SR3_DRV_LO   = 2;
    localparam int         SR3_DUM_LO   = 4;
    localparam logic [3:0] BP_RST       = 4'h0;
    localparam logic [1:0] DUM_RST      = 2'h0;
    localparam logic [1:0] DRV_RST      = 2'h0;
    localparam logic [2:0] DUM_00       = 3'h3;
    localparam logic [2:0] DUM_01       = 3'h2;
    localparam logic [2:0] DUM_10       = 3'h4;
    localparam logic [2:0] DUM_11       = 3'h5;
    localparam logic [3:0] PIN_IDLE     = 4'hE;
    localparam int         CLK_NS       = 100;
    localparam int         WR_TIME_NS   = 10000;
    localparam int         WR_CYC       = (WR_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [6:0] WR_CYC_M1    = 7'(WR_CYC - 1);

    typedef enum logic [2:0] {
        OP_PROG  = 3'h0,
        OP_QPROG = 3'h1,
        OP_SECT  = 3'h2,
        OP_HBLK  = 3'h3,
        OP_BLK   = 3'h4,
        OP_CHIP  = 3'h5
    } fsp_op_kind_t;

    typedef struct packed {
        fsp_op_kind_t kind;
        logic         hit_bp;
        logic         hit_boot;
        logic         hit_otp;
    } fsp_op_t;

    typedef struct packed {
        logic [1:0] dummy;
        logic [1:0] drive;
    } fsp_cfg3_t;

    typedef struct packed {
        logic [3:0] bp;
        logic       boot_lock_enable;
        logic       tb;
        logic       bl4k;
        logic       otp_lock;
    } fsp_prot_t;

    typedef enum logic [2:0] {
        W_IDLE = 3'h1,
        W_STAT = 3'h2,
        W_OP   = 3'h4
    } fsp_wstate_t;
endpackage : fsp_pkg

// file: rtl/fsp_status_regs.sv
// status, protection and config register bank with its serial front end
`timescale 1ns/10ps
module fsp_status_regs (
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              sclk_i,
    input  wire logic              cs_n_i,
    input  wire logic              si_i,
    input  wire logic              wp_n_i,
    output logic                   so_o,
    output logic                   so_oe_o,
    input  wire logic              otp_mode_i,
    input  wire logic              quad_mode_i,
    input  wire logic              op_valid_i,
    input  wire fsp_pkg::fsp_op_t  op_i,
    input  wire logic              op_done_i,
    input  wire logic              cfg3_we_i,
    input  wire fsp_pkg::fsp_cfg3_t cfg3_i,
    output logic                   op_grant_o,
    output logic                   op_refuse_o,
    output logic [7:0]             status_o,
    output logic                   sr2_wip_o,
    output logic [7:0]             sr3_o,
    output fsp_pkg::fsp_prot_t     prot_o,
    output logic                   wp_func_o,
    output logic                   hold_func_o,
    output logic                   reset_func_o,
    output logic [2:0]             dummy_bytes_o,
    output logic [1:0]             drive_sel_o
);

////////////////////////////////////////////////////////////
// pin synchronisers and edge detect

logic [3:0] pin_meta;
logic [3:0] pin_sync;
logic       sclk_q;
logic       cs_q;

always_ff @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        pin_meta <= fsp_pkg::PIN_IDLE;
        pin_sync <= fsp_pkg::PIN_IDLE;
        sclk_q   <= 1'b0;
        cs_q     <= 1'b1;
    end
    else
    begin
        pin_meta <= {wp_n_i, si_i, cs_n_i, sclk_i};
        pin_sync <= pin_meta;
        sclk_q   <= pin_sync[0];
        cs_q     <= pin_sync[1];
    end
end

logic cs_n;
logic si;
logic wp_n;
logic rise;
logic fall;
logic cs_rise;

assign cs_n    = pin_sync[1];
assign si      = pin_sync[2];
assign wp_n    = pin_sync[3];
assign rise    = pin_sync[0] & ~sclk_q & ~cs_n;
assign fall    = ~pin_sync[0] & sclk_q & ~cs_n;
assign cs_rise = cs_n & ~cs_q;

////////////////////////////////////////////////////////////
// register state

logic [3:0]  bp;
logic        status_protect_lock;
logic        boot_lock_enable;
logic        otp_lock;
logic        cpd;
logic        pfs;
logic        bl4k;
logic        tb;
logic        write_enable_latch;
logic        write_in_progress;
logic [1:0]  dum;
logic [1:0]  drv;
logic [7:0]  cmd;
logic [7:0]  wdat;
logic [7:0]  shin;
logic [7:0]  shout;
logic [2:0]  bit_cnt;
logic [1:0]  byte_cnt;
logic [6:0]  tmr;
logic        wr_otp;
fsp_pkg::fsp_wstate_t wst;

// the pin only protects while its function is live
logic hardware_protected_mode;
assign hardware_protected_mode = status_protect_lock & ~wp_n & ~cpd & ~quad_mode_i;

logic [7:0] rd_status;
always_comb
begin
    rd_status = 8'h00;
    rd_status[fsp_pkg::SR_WIP] = write_in_progress;
    rd_status[fsp_pkg::SR_WEL] = write_enable_latch;
    if (otp_mode_i)
    begin
        rd_status[fsp_pkg::SR_OTPL] = otp_lock;
        rd_status[fsp_pkg::SR_CPD]  = cpd;
        rd_status[fsp_pkg::SR_PFS]  = pfs;
        rd_status[fsp_pkg::SR_BL4K] = bl4k;
        rd_status[fsp_pkg::SR_TB]   = tb;
    end
    else
    begin
        rd_status[fsp_pkg::SR_SRP] = status_protect_lock;
        rd_status[fsp_pkg::SR_EBL] = boot_lock_enable;
        rd_status[fsp_pkg::SR_BP_LO +: 4] = bp;
    end
end

logic [7:0] rd_sr3;
always_comb
begin
    rd_sr3 = 8'h00;
    rd_sr3[fsp_pkg::SR3_DUM_LO +: 2] = dum;
    rd_sr3[fsp_pkg::SR3_DRV_LO +: 2] = drv;
end

////////////////////////////////////////////////////////////
// serial shift in

always_ff @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        shin     <= 8'h00;
        cmd      <= 8'h00;
        wdat     <= 8'h00;
        bit_cnt  <= 3'h0;
        byte_cnt <= 2'h0;
    end
    else if (cs_n)
    begin
        bit_cnt  <= 3'h0;
        byte_cnt <= 2'h0;
    end
    else if (rise)
    begin
        shin    <= {shin[6:0], si};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7)
        begin
            if (byte_cnt == 2'h0)
                cmd <= {shin[6:0], si};
            if (byte_cnt == 2'h1)
                wdat <= {shin[6:0], si};
            if (byte_cnt != 2'h3)
                byte_cnt <= byte_cnt + 2'h1;
        end
    end
end

////////////////////////////////////////////////////////////
// serial shift out, re-sampled every byte so polling sees updates

logic rd_cmd;
assign rd_cmd = (cmd == fsp_pkg::CMD_RD_STAT) | (cmd == fsp_pkg::CMD_RD_STAT3);

always_ff @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        so_o    <= 1'b0;
        so_oe_o <= 1'b0;
        shout   <= 8'h00;
    end
    else if (cs_n)
        so_oe_o <= 1'b0;
    else if (fall && rd_cmd && byte_cnt != 2'h0)
    begin
        so_oe_o <= 1'b1;
        if (bit_cnt == 3'h0)
        begin
            if (cmd == fsp_pkg::CMD_RD_STAT)
            begin
                so_o  <= rd_status[7];
                shout <= {rd_status[6:0], 1'b0};
            end
            else
            begin
                so_o  <= rd_sr3[7];
                shout <= {rd_sr3[6:0], 1'b0};
            end
        end
        else
        begin
            so_o  <= shout[7];
            shout <= {shout[6:0], 1'b0};
        end
    end
end

////////////////////////////////////////////////////////////
// operation gating

logic op_ok;
logic op_take;
logic wr_take;
logic cyc_end;

always_comb
begin
    if (op_i.kind == fsp_pkg::OP_CHIP)
        op_ok = (bp == 4'h0) & ~boot_lock_enable;
    else
        op_ok = ~((bp != 4'h0) & op_i.hit_bp)
              & ~(boot_lock_enable & op_i.hit_boot)
              & ~(otp_lock & op_i.hit_otp);
end

assign op_take = op_valid_i & (wst == fsp_pkg::W_IDLE) & write_enable_latch & op_ok;
// a status write needs exactly 16 bits before deselect
assign wr_take = cs_rise & (cmd == fsp_pkg::CMD_WR_STAT) & (byte_cnt == 2'h2)
               & (bit_cnt == 3'h0) & write_enable_latch & ~hardware_protected_mode & ~op_valid_i
               & (wst == fsp_pkg::W_IDLE);
assign cyc_end = ((wst == fsp_pkg::W_STAT) & (tmr == fsp_pkg::WR_CYC_M1))
               | ((wst == fsp_pkg::W_OP) & op_done_i);

always_ff @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        op_grant_o  <= 1'b0;
        op_refuse_o <= 1'b0;
    end
    else
    begin
        op_grant_o  <= op_take;
        op_refuse_o <= op_valid_i & ~op_take;
    end
end

////////////////////////////////////////////////////////////
// internal cycle sequencer

always_ff @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        wst    <= fsp_pkg::W_IDLE;
        write_in_progress    <= 1'b0;
        tmr    <= 7'h00;
        wr_otp <= 1'b0;
    end
    else
    begin
        case (wst)
            fsp_pkg::W_IDLE:
            begin
                tmr <= 7'h00;
                if (op_take)
                begin
                    wst <= fsp_pkg::W_OP;
                    write_in_progress <= 1'b1;
                end
                else if (wr_take)
                begin
                    wst    <= fsp_pkg::W_STAT;
                    write_in_progress    <= 1'b1;
                    wr_otp <= otp_mode_i;
                end
            end
            fsp_pkg::W_STAT, fsp_pkg::W_OP:
            begin
                tmr <= tmr + 7'h01;
                if (cyc_end)
                begin
                    wst <= fsp_pkg::W_IDLE;
                    write_in_progress <= 1'b0;
                end
            end
            default:
            begin
                wst <= fsp_pkg::W_IDLE;
                write_in_progress <= 1'b0;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////
// write enable latch

always_ff @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
        write_enable_latch <= 1'b0;
    else if (cyc_end)
        write_enable_latch <= 1'b0;
    else if (cs_rise && byte_cnt == 2'h1 && bit_cnt == 3'h0 && !write_in_progress)
    begin
        if (cmd == fsp_pkg::CMD_SET_WEL)
            write_enable_latch <= 1'b1;
        else if (cmd == fsp_pkg::CMD_CLR_WEL)
            write_enable_latch <= 1'b0;
    end
end

////////////////////////////////////////////////////////////
// status bits, applied when the self-timed write ends

always_ff @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        bp  <= fsp_pkg::BP_RST;
        status_protect_lock <= 1'b0;
        boot_lock_enable <= 1'b0;
    end
    else if (cyc_end && wst == fsp_pkg::W_STAT && !wr_otp)
    begin
        bp  <= wdat[fsp_pkg::SR_BP_LO +: 4];
        status_protect_lock <= wdat[fsp_pkg::SR_SRP];
        boot_lock_enable <= wdat[fsp_pkg::SR_EBL];
    end
end

// one-time bits only ever go from 0 to 1
always_ff @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        otp_lock <= 1'b0;
        cpd      <= 1'b0;
        pfs      <= 1'b0;
        bl4k     <= 1'b0;
        tb       <= 1'b0;
    end
    else if (cyc_end && wst == fsp_pkg::W_STAT && wr_otp)
    begin
        otp_lock <= otp_lock | wdat[fsp_pkg::SR_OTPL];
        cpd      <= cpd | wdat[fsp_pkg::SR_CPD];
        pfs      <= pfs | wdat[fsp_pkg::SR_PFS];
        bl4k     <= bl4k | wdat[fsp_pkg::SR_BL4K];
        tb       <= tb | wdat[fsp_pkg::SR_TB];
    end
end

////////////////////////////////////////////////////////////
// volatile config register three

always_ff @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        dum <= fsp_pkg::DUM_RST;
        drv <= fsp_pkg::DRV_RST;
    end
    else if (cfg3_we_i)
    begin
        dum <= cfg3_i.dummy;
        drv <= cfg3_i.drive;
    end
end

////////////////////////////////////////////////////////////
// registered outputs

always_ff @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        status_o      <= 8'h00;
        sr2_wip_o     <= 1'b0;
        sr3_o         <= 8'h00;
        prot_o        <= '0;
        wp_func_o     <= 1'b0;
        hold_func_o   <= 1'b0;
        reset_func_o  <= 1'b0;
        dummy_bytes_o <= fsp_pkg::DUM_00;
        drive_sel_o   <= fsp_pkg::DRV_RST;
    end
    else
    begin
        status_o     <= rd_status;
        sr2_wip_o    <= write_in_progress;
        sr3_o        <= rd_sr3;
        prot_o       <= '{bp, boot_lock_enable, tb, bl4k, otp_lock};
        wp_func_o    <= ~cpd & ~quad_mode_i;
        hold_func_o  <= ~cpd & ~quad_mode_i & ~pfs;
        reset_func_o <= ~cpd & ~quad_mode_i & pfs;
        drive_sel_o  <= drv;
        case (dum)
            2'h0:    dummy_bytes_o <= fsp_pkg::DUM_00;
            2'h1:    dummy_bytes_o <= fsp_pkg::DUM_01;
            2'h2:    dummy_bytes_o <= fsp_pkg::DUM_10;
            default: dummy_bytes_o <= fsp_pkg::DUM_11;
        endcase
    end
end

////////////////////////////////////////////////////////////
// checks

localparam int WR_MAX = 102;

default clocking cb @(posedge clk_i); endclocking
default disable iff (!arst_n_i);

sequence s_wr_start;
    wr_take;
endsequence

sequence s_chip_bad;
    op_valid_i && op_i.kind == fsp_pkg::OP_CHIP && (bp != 4'h0 || boot_lock_enable);
endsequence

AST_WIP_SPAN: assert property (s_wr_start |=> write_in_progress ##[1:WR_MAX] !write_in_progress)
    else $error("status write cycle busy span wrong");
AST_NO_WEL: assert property (op_valid_i && !write_enable_latch |=> !op_grant_o && op_refuse_o)
    else $error("operation granted without write enable");
AST_BP_HIT: assert property (op_valid_i && op_i.hit_bp && bp != 4'h0
    && op_i.kind != fsp_pkg::OP_CHIP |=> op_refuse_o)
    else $error("protected area not refused");
AST_HPM_HOLD: assert property (hardware_protected_mode && !write_in_progress && !op_valid_i |=> !write_in_progress && $stable(bp) && $stable(status_protect_lock))
    else $error("protect bits changed under hardware protection");
AST_CHIP: assert property (s_chip_bad |=> op_refuse_o)
    else $error("chip erase not refused");
AST_OTP_ONCE: assert property ($rose(otp_lock) |-> ##1 otp_lock [*8])
    else $error("otp lock cleared");
AST_WEL_END: assert property ($fell(write_in_progress) |-> !write_enable_latch)
    else $error("write enable latch not cleared at cycle end");
AST_SR2: assert property (sr2_wip_o == status_o[fsp_pkg::SR_WIP])
    else $error("busy bits disagree");
AST_PINS_OFF: assert property (cpd |=> !hold_func_o && !reset_func_o && !wp_func_o)
    else $error("pin function live while disabled");
AST_SR3_RSV: assert property (sr3_o[7:6] == 2'h0 && sr3_o[1:0] == 2'h0)
    else $error("reserved config bits nonzero");

endmodule : fsp_status_regs

// file: bench/fsp_host_model.sv
// host side serial controller model for the status register link
`timescale 1ns/10ps
module fsp_host_model (
    input  wire logic clk_i,
    input  wire logic so_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o
);
    // link clock stands still low between frames (mode 0)
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    task automatic half;
        repeat (4) @(negedge clk_i);
    endtask : half

    // nw bits out msb first, then nr bits in; read bit taken late in high phase for margin
    task automatic xfer(input logic [15:0] w, input int nw, input int nr,
                        output logic [15:0] r);
        r      = 16'h0000;
        cs_n_o = 1'b0;
        for (int i = 0; i < nw + nr; i++)
        begin
            si_o = (i < nw) ? w[15 - i] : ~si_o;
            half();
            sclk_o = 1'b1;
            half();
            if (i >= nw)
                r = {r[14:0], so_i};
            sclk_o = 1'b0;
        end
        half();
        cs_n_o = 1'b1;
        si_o   = ~si_o;
        repeat (8) @(negedge clk_i);
    endtask : xfer

    // poll busy bit before the next command
    task automatic wait_idle(output logic [7:0] st);
        logic [15:0] r;
        st = 8'hFF;
        for (int n = 0; n < 20 && st[0] !== 1'b0; n++)
        begin
            xfer({fsp_pkg::CMD_RD_STAT, 8'h00}, 8, 8, r);
            st = r[7:0];
        end
    endtask : wait_idle
endmodule : fsp_host_model

// file: bench/fsp_status_regs_test.sv
// self-checking bench of the status register bank
`timescale 1ns/10ps
module fsp_status_regs_test;
    logic               clk_i, arst_n_i, sclk, cs_n, si, wp_n_i, so, so_oe;
    logic               otp_mode_i, quad_mode_i, op_valid_i, op_done_i, cfg3_we_i;
    logic               grant, refuse, sr2_wip, wp_f, hold_f, rst_f;
    fsp_pkg::fsp_op_t   op_i;
    fsp_pkg::fsp_cfg3_t cfg3_i;
    fsp_pkg::fsp_prot_t prot;
    logic [7:0]         status, sr3, st, d;
    logic [2:0]         dummy, k;
    logic [1:0]         drive;
    logic [3:0]         c;
    logic [15:0]        r;
    int                 err_total, comparisons, seed, cycles;

    fsp_status_regs dut_u (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .si_i(si), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe),
        .otp_mode_i(otp_mode_i), .quad_mode_i(quad_mode_i),
        .op_valid_i(op_valid_i), .op_i(op_i), .op_done_i(op_done_i),
        .cfg3_we_i(cfg3_we_i), .cfg3_i(cfg3_i), .op_grant_o(grant),
        .op_refuse_o(refuse), .status_o(status), .sr2_wip_o(sr2_wip),
        .sr3_o(sr3), .prot_o(prot), .wp_func_o(wp_f), .hold_func_o(hold_f),
        .reset_func_o(rst_f), .dummy_bytes_o(dummy), .drive_sel_o(drive)
    );

    // a released data line shows the inverse, so a missing enable reads wrong
    fsp_host_model host_u (
        .clk_i(clk_i), .so_i(so_oe ? so : ~so), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si)
    );

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // a hang shows up as a missing busy clear; cut it well past the longest run
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            stop_test();
        end
    end

    task automatic stop_test;
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [2:0] exp_dummy(input logic [1:0] code);
        case (code)
            2'h0: return 3'h3;
            2'h1: return 3'h2;
            2'h2: return 3'h4;
            default: return 3'h5;
        endcase
    endfunction : exp_dummy

    // answer stands exactly one cycle, one clock after the request
    task automatic op(input logic [2:0] kd, input logic [2:0] h, input logic [1:0] e);
        logic [1:0] a;
        op_i       = fsp_pkg::fsp_op_t'({kd, h});
        op_valid_i = 1'b1;
        @(negedge clk_i);
        op_valid_i = 1'b0;
        a          = {grant, refuse};
        @(negedge clk_i);
        chk({4'h0, a, grant, refuse}, {4'h0, e, 2'b00});
    endtask : op

    task automatic done;
        op_done_i = 1'b1;
        @(negedge clk_i);
        op_done_i = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask : done

    task automatic wren;
        host_u.xfer({fsp_pkg::CMD_SET_WEL, 8'h00}, 8, 0, r);
    endtask : wren

    task automatic wr(input logic [7:0] dv, input logic b, input logic [7:0] e);
        wren();
        host_u.xfer({fsp_pkg::CMD_WR_STAT, dv}, 16, 0, r);
        chk({6'h00, status[0], sr2_wip}, {6'h00, b, b});
        host_u.wait_idle(st);
        chk(st, e);
        chk(status, e);
    endtask : wr

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed        = 11665;
        err_total   = 0;
        comparisons = 0;
        cycles      = 0;
        arst_n_i    = 1'b0;
        wp_n_i      = 1'b1;
        otp_mode_i  = 1'b0;
        quad_mode_i = 1'b0;
        op_valid_i  = 1'b0;
        op_done_i   = 1'b0;
        cfg3_we_i   = 1'b0;
        op_i        = '0;
        cfg3_i      = '0;
        repeat (10) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk(status, 8'h00);
        chk({5'h00, wp_f, hold_f, rst_f}, 8'h06);
        chk({dummy, drive, 3'h0}, 8'h60);
        k = 3'($unsigned($random(seed)) % 5);
        op(k, 3'h0, 2'b01);
        wren();
        chk(status, 8'h02);
        op(k, 3'h0, 2'b10);
        repeat (3) @(negedge clk_i);
        chk({6'h00, status[0], sr2_wip}, 8'h03);
        host_u.xfer({fsp_pkg::CMD_RD_STAT, 8'h00}, 8, 8, r);
        chk(r[7:0], 8'h03);
        done();
        chk(status, 8'h00);
        d = 8'($random(seed));
        d = {2'b10, d[5:2] | 4'h1, d[1:0]};
        wr(d, 1'b1, {d[7:2], 2'b00});
        chk({prot.bp, 4'h0}, {d[5:2], 4'h0});
        wren();
        k = 3'($unsigned($random(seed)) % 5);
        op(k, 3'h4, 2'b01);
        op(3'h5, 3'h0, 2'b01);
        wp_n_i = 1'b0;
        wr(8'h00, 1'b0, {d[7:2], 2'b10});
        quad_mode_i = 1'b1;
        wr(8'h40, 1'b1, 8'h40);
        chk({prot.bp, prot.boot_lock_enable, wp_f, hold_f, rst_f}, 8'h08);
        quad_mode_i = 1'b0;
        wp_n_i      = 1'b1;
        wren();
        op(k, 3'h2, 2'b01);
        op(3'h5, 3'h0, 2'b01);
        op(k, 3'h5, 2'b10);
        done();
        otp_mode_i = 1'b1;
        wr(8'h24, 1'b1, 8'h20);
        chk({5'h00, wp_f, hold_f, rst_f}, 8'h05);
        wr(8'hC8, 1'b1, 8'hE8);
        chk({5'h00, wp_f, hold_f, rst_f}, 8'h00);
        wr(8'h00, 1'b1, 8'hE8);
        wr(8'h10, 1'b1, 8'hF8);
        chk({5'h00, prot.tb, prot.bl4k, prot.otp_lock}, 8'h07);
        wren();
        op(3'h0, 3'h1, 2'b01);
        host_u.xfer({fsp_pkg::CMD_CLR_WEL, 8'h00}, 8, 0, r);
        chk(status, 8'hF8);
        host_u.xfer({fsp_pkg::CMD_WR_STAT, 8'h00}, 16, 0, r);
        chk({6'h00, status[0], sr2_wip}, 8'h00);
        op(3'h0, 3'h0, 2'b01);
        d = 8'($random(seed));
        for (int i = 0; i < 16; i++)
        begin
            c         = 4'(i) + d[3:0];
            cfg3_i    = fsp_pkg::fsp_cfg3_t'(c);
            cfg3_we_i = 1'b1;
            @(negedge clk_i);
            cfg3_we_i = 1'b0;
            repeat (2) @(negedge clk_i);
            chk(sr3, {2'b00, c, 2'b00});
            chk({dummy, drive, 3'h0}, {exp_dummy(c[3:2]), c[1:0], 3'h0});
        end
        host_u.xfer({fsp_pkg::CMD_RD_STAT3, 8'h00}, 8, 16, r);
        chk(r[15:8], {2'b00, c, 2'b00});
        chk(r[7:0], {2'b00, c, 2'b00});
        chk({7'h00, so_oe}, 8'h00);
        stop_test();
    end
endmodule : fsp_status_regs_test
